// ==== erw_pkg.sv ====
`default_nettype none
package erw_pkg;
    // Register byte offsets
    localparam logic [3:0] TIMING_OFS = 4'h0;
    localparam logic [3:0] ACCESS_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [3:0] DATA_OFS = 4'hc;
    // Timing register fields
    localparam int LEAD_RD_POS = 0;
    localparam int ACT_RD_POS = 4;
    localparam int TRAIL_RD_POS = 8;
    localparam int LEAD_WR_POS = 12;
    localparam int ACT_WR_POS = 16;
    localparam int TRAIL_WR_POS = 20;
    localparam int READY_EN_POS = 24;
    localparam int READY_MODE_POS = 25;
    localparam int DOUBLE_SEL_POS = 26;
    localparam logic [31:0] TIMING_RST = 32'h0000_0000;
    localparam logic [31:0] ACCESS_RST = 32'h0000_0000;
    // Access register: bit 31 write direction, low bits address
    localparam int ACC_DIR_POS = 31;
    localparam int ASYNC_REF_SUB = 2;
    // Timing to system clock period ratio; TICK_DIV is unused, the tick comes from iface_timing_clock_i
    localparam int TIM_PERIOD_NS = 20;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_DIV = TIM_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ALIGN = 3'b001,
        ST_LEAD = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_WAIT = 3'b100,
        ST_TRAIL = 3'b101
    } erw_state_type;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic we_n;
        logic rnw;
    } erw_strobe_type;
endpackage
`default_nettype wire

// ==== erw_ready_wait.sv ====
// Functional notes
// - Double mode: lead phase starts on rising bus clock, else one alignment cycle first.
// - All strobes and controls inactive during alignment cycles.
// - Address outputs hold last presented address during inactive cycles.
// - Synchronous mode: first ready sample at lead plus active periods.
// - Asynchronous mode: first ready sample at lead plus active minus two.
// - Synchronous: complete on ready high, else resample every period.
// - Asynchronous: complete on first high sample, resample each period.
// - Ready disabled: ignore ready, use programmed lead, active, trail only.
`timescale 1ns/1ps
`default_nettype none
module erw_ready_wait #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic ext_ready_in_i,
    input wire logic iface_timing_clock_i,
    input wire logic [DATA_W-1:0] ext_data_i,
    output logic [DATA_W-1:0] ext_data_o,
    output logic ext_data_oe_o,
    output logic bus_clock_out_o,
    output logic [ADDR_W-1:0] ext_addr_out_o,
    output erw_pkg::erw_strobe_type strobe_o
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] rdy_sync_q, rdy_sync_d;
    logic [1:0] tclk_sync_q, tclk_sync_d;
    logic tclk_last_q, tclk_last_d;
    logic tick;

    always_comb begin
        rdy_sync_d = {rdy_sync_q[0], ext_ready_in_i};
        tclk_sync_d = {tclk_sync_q[0], iface_timing_clock_i};
        tclk_last_d = tclk_sync_q[1];
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdy_sync_q <= 2'h0;
            tclk_sync_q <= 2'h0;
            tclk_last_q <= 1'b0;
        end else begin
            rdy_sync_q <= rdy_sync_d;
            tclk_sync_q <= tclk_sync_d;
            tclk_last_q <= tclk_last_d;
        end
    end

    // Rising edge of the timing clock is the tick every counter steps on
    assign tick = tclk_sync_q[1] & ~tclk_last_q;

    // ----------------------------------------
    // Registers and access engine
    // ----------------------------------------
    logic [31:0] timing_q, timing_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic dir_wr_q, dir_wr_d;
    logic pend_q, pend_d;
    logic phase_q, phase_d;
    logic [3:0] cnt_q, cnt_d;
    logic [4:0] elapsed_q, elapsed_d;
    logic [31:0] rd_q, rd_d;
    logic ack_q, ack_d;
    erw_pkg::erw_state_type state_q, state_d;
    erw_pkg::erw_strobe_type strb_q, strb_d;

    logic [3:0] lead_c, act_c, trail_c;
    logic rdy_en, rdy_async, dbl;
    logic [4:0] first_sample;
    logic busy;
    logic fin;

    always_comb begin
        rdy_en = timing_q[erw_pkg::READY_EN_POS];
        rdy_async = timing_q[erw_pkg::READY_MODE_POS];
        dbl = timing_q[erw_pkg::DOUBLE_SEL_POS];
        if (dir_wr_q) begin
            lead_c = timing_q[erw_pkg::LEAD_WR_POS +: 4];
            act_c = timing_q[erw_pkg::ACT_WR_POS +: 4];
            trail_c = timing_q[erw_pkg::TRAIL_WR_POS +: 4];
        end else begin
            lead_c = timing_q[erw_pkg::LEAD_RD_POS +: 4];
            act_c = timing_q[erw_pkg::ACT_RD_POS +: 4];
            trail_c = timing_q[erw_pkg::TRAIL_RD_POS +: 4];
        end
        if (rdy_async) begin
            first_sample = 5'({1'b0, lead_c} + {1'b0, act_c} - 5'(erw_pkg::ASYNC_REF_SUB));
        end else begin
            first_sample = 5'({1'b0, lead_c} + {1'b0, act_c});
        end
        busy = pend_q | (state_q != erw_pkg::ST_IDLE);
    end

    always_comb begin
        timing_d = timing_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        dir_wr_d = dir_wr_q;
        pend_d = pend_q;
        phase_d = phase_q;
        cnt_d = cnt_q;
        elapsed_d = elapsed_q;
        state_d = state_q;
        strb_d = strb_q;
        rd_d = rd_q;
        ack_d = 1'b0;
        fin = 1'b0;

        // ----------------------------------------
        // Avalon slave
        // ----------------------------------------
        // One wait cycle, then ack; busy access register stalls
        if ((avs_read_i | avs_write_i) && !ack_q) begin
            if (avs_write_i) begin
                // Access register refused until the engine is idle
                ack_d = (avs_address_i != erw_pkg::ACCESS_OFS) || !busy;
            end else begin
                ack_d = 1'b1;
                unique case (avs_address_i)
                    erw_pkg::TIMING_OFS: rd_d = timing_q;
                    erw_pkg::ACCESS_OFS: rd_d = {dir_wr_q, {(31-ADDR_W){1'b0}}, addr_q};
                    erw_pkg::STATUS_OFS: rd_d = {28'h0, 1'b0, state_q};
                    erw_pkg::DATA_OFS: rd_d = {{(32-DATA_W){1'b0}}, rdata_q};
                    default: rd_d = 32'h0000_0000;
                endcase
            end
        end

        // Write lands at the edge where the master sees waitrequest low
        if (avs_write_i && ack_q) begin
            unique case (avs_address_i)
                erw_pkg::TIMING_OFS: begin
                    timing_d = avs_writedata_i;
                end
                erw_pkg::ACCESS_OFS: begin
                    addr_d = avs_writedata_i[ADDR_W-1:0];
                    dir_wr_d = avs_writedata_i[erw_pkg::ACC_DIR_POS];
                    pend_d = 1'b1;
                end
                erw_pkg::DATA_OFS: begin
                    wdata_d = avs_writedata_i[DATA_W-1:0];
                end
                default: begin
                    // Unmapped write is acknowledged and dropped
                    fin = 1'b0;
                end
            endcase
        end

        // ----------------------------------------
        // Access sequencing
        // ----------------------------------------
        if (tick) begin
            // Bus clock is held high, or half the timing clock when doubled
            phase_d = dbl ? ~phase_q : 1'b1;
            if (state_q != erw_pkg::ST_IDLE) begin
                elapsed_d = elapsed_q + 5'h1;
            end
            unique case (state_q)
                erw_pkg::ST_IDLE: begin
                    if (pend_q) begin
                        pend_d = 1'b0;
                        elapsed_d = 5'h0;
                        if (dbl && phase_q) begin
                            state_d = erw_pkg::ST_ALIGN;
                            strb_d = '{cs_n: 1'b1, rd_n: 1'b1, we_n: 1'b1, rnw: 1'b1};
                        end else begin
                            state_d = erw_pkg::ST_LEAD;
                            cnt_d = lead_c;
                            strb_d = '{cs_n: 1'b0, rd_n: 1'b1, we_n: 1'b1, rnw: ~dir_wr_q};
                        end
                    end
                end
                erw_pkg::ST_ALIGN: begin
                    elapsed_d = 5'h0;
                    state_d = erw_pkg::ST_LEAD;
                    cnt_d = lead_c;
                    strb_d = '{cs_n: 1'b0, rd_n: 1'b1, we_n: 1'b1, rnw: ~dir_wr_q};
                end
                erw_pkg::ST_LEAD: begin
                    if (cnt_q <= 4'h1) begin
                        state_d = erw_pkg::ST_ACTIVE;
                        cnt_d = act_c;
                        strb_d.rd_n = dir_wr_q;
                        strb_d.we_n = ~dir_wr_q;
                    end else begin
                        cnt_d = cnt_q - 4'h1;
                    end
                end
                erw_pkg::ST_ACTIVE: begin
                    if (!rdy_en) begin
                        if (cnt_q <= 4'h1) begin
                            fin = 1'b1;
                        end else begin
                            cnt_d = cnt_q - 4'h1;
                        end
                    end else if (elapsed_q + 5'h1 >= first_sample) begin
                        // first sample taken at this tick
                        if (rdy_sync_q[1]) begin
                            fin = 1'b1;
                        end else begin
                            state_d = erw_pkg::ST_WAIT;
                        end
                    end
                end
                erw_pkg::ST_WAIT: begin
                    // partner keeps ready high once raised
                    if (rdy_sync_q[1]) begin
                        fin = 1'b1;
                    end
                end
                erw_pkg::ST_TRAIL: begin
                    // Trail of zero still costs one period before release
                    if (cnt_q <= 4'h1) begin
                        state_d = erw_pkg::ST_IDLE;
                        strb_d = '{cs_n: 1'b1, rd_n: 1'b1, we_n: 1'b1, rnw: 1'b1};
                    end else begin
                        cnt_d = cnt_q - 4'h1;
                    end
                end
                default: state_d = erw_pkg::ST_IDLE;
            endcase
            // End of active phase: strobes rise on the completing tick
            if (fin) begin
                state_d = erw_pkg::ST_TRAIL;
                rdata_d = dir_wr_q ? rdata_q : ext_data_i;
                strb_d.rd_n = 1'b1;
                strb_d.we_n = 1'b1;
                cnt_d = trail_c;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timing_q <= erw_pkg::TIMING_RST;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            dir_wr_q <= 1'b0;
            pend_q <= 1'b0;
            phase_q <= 1'b0;
            cnt_q <= 4'h0;
            elapsed_q <= 5'h0;
            state_q <= erw_pkg::ST_IDLE;
            strb_q <= '{cs_n: 1'b1, rd_n: 1'b1, we_n: 1'b1, rnw: 1'b1};
            rd_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            timing_q <= timing_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            dir_wr_q <= dir_wr_d;
            pend_q <= pend_d;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            elapsed_q <= elapsed_d;
            state_q <= state_d;
            strb_q <= strb_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign avs_readdata_o = rd_q;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign bus_clock_out_o = phase_q;
    assign ext_addr_out_o = addr_q;
    assign ext_data_o = wdata_q;
    assign ext_data_oe_o = ~strb_q.we_n;
    assign strobe_o = strb_q;
endmodule
`default_nettype wire

// ==== erw_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module erw_chk #(
    parameter int ADDR_W = 19
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic avs_read_i,
    input wire logic avs_waitrequest_o,
    input wire logic ext_data_oe_o,
    input wire logic bus_clock_out_o,
    input wire logic [ADDR_W-1:0] ext_addr_out_o,
    input wire erw_pkg::erw_strobe_type strobe_o
);
    // ----------------
    // Pin relations
    // ----------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    property p_ack; $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_ack: assert property (p_ack) else $error("read answer late");
    property p_align; $fell(strobe_o.cs_n) |-> bus_clock_out_o && strobe_o.rd_n && strobe_o.we_n; endproperty
    a_align: assert property (p_align) else $error("lead not on bus clock high");
    property p_idle; strobe_o.cs_n |-> strobe_o.rd_n && strobe_o.we_n && !ext_data_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("strobe active while deselected");
    property p_run; !strobe_o.cs_n && $past(!strobe_o.cs_n) |-> $stable(ext_addr_out_o); endproperty
    a_run: assert property (p_run) else $error("address moved in access");
    // Two cycles only: a queued access may legally start soon after
    property p_hold; $rose(strobe_o.cs_n) |=> $stable(ext_addr_out_o)[*2]; endproperty
    a_hold: assert property (p_hold) else $error("address not held");
    property p_rd; !strobe_o.rd_n |-> strobe_o.rnw && strobe_o.we_n; endproperty
    a_rd: assert property (p_rd) else $error("read strobe with write direction");
    property p_wr; !strobe_o.we_n |-> !strobe_o.rnw && ext_data_oe_o; endproperty
    a_wr: assert property (p_wr) else $error("write strobe without drive");
    property p_oe; ext_data_oe_o |-> !strobe_o.we_n; endproperty
    a_oe: assert property (p_oe) else $error("data driven outside write strobe");
endmodule
bind erw_ready_wait erw_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_data_oe_o(ext_data_oe_o), .bus_clock_out_o(bus_clock_out_o),
    .ext_addr_out_o(ext_addr_out_o), .strobe_o(strobe_o));
`default_nettype wire

// ==== erw_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module erw_mem_model (
    input wire logic tclk_i,
    input wire logic [3:0] wait_i,
    input wire erw_pkg::erw_strobe_type strobe_i,
    input wire logic [15:0] rdata_i,
    output logic ready_o,
    output logic [15:0] data_o
);
    int cnt = 0;
    initial ready_o = 1'b0;
    always @(posedge tclk_i) begin
        cnt = strobe_i.cs_n ? 0 : cnt + 1;
        ready_o <= !strobe_i.cs_n && cnt > wait_i;
    end
    // Released bus shows the inverse so stale data never matches
    assign data_o = strobe_i.rd_n ? ~rdata_i : rdata_i;
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic tclk = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0] wait_n = 4'h0;
    logic [15:0] pdat = 16'h0;
    logic [31:0] rdq, rdat, tv;
    logic wreq, rdy, oe, bclk, rdy_end;
    logic [15:0] xin, xout;
    logic [18:0] xa;
    erw_pkg::erw_strobe_type stb;
    int err_total = 0;
    int total_checks = 0;
    int lead_c = 0, act_c = 0, lead_s = 0, act_s = 0;
    // Lead, active, trail, ready on, async, double, write, partner wait
    int cfg[7][8] = '{'{1,3,1,0,0,0,1,15}, '{2,4,1,1,0,0,0,0}, '{1,3,2,1,0,0,1,12},
        '{3,3,1,1,1,0,0,0}, '{1,5,1,1,1,0,1,14}, '{2,3,1,0,0,1,0,15}, '{1,4,1,1,0,1,1,0}};
    erw_ready_wait dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdq), .avs_waitrequest_o(wreq), .ext_ready_in_i(rdy),
        .iface_timing_clock_i(tclk), .ext_data_i(xin), .ext_data_o(xout), .ext_data_oe_o(oe),
        .bus_clock_out_o(bclk), .ext_addr_out_o(xa), .strobe_o(stb));
    erw_mem_model mem (.tclk_i(tclk), .wait_i(wait_n), .strobe_i(stb), .rdata_i(pdat), .ready_o(rdy), .data_o(xin));
    initial forever #5 clk_i = ~clk_i;
    initial begin
        #3;
        forever #40 tclk = ~tclk;
    end
    // ----------------
    // Phase lengths seen on the strobes
    // ----------------
    always @(posedge clk_i) begin
        if (!(stb.rd_n & stb.we_n)) begin
            if (act_c == 0) lead_s = lead_c;
            act_c++;
        end else if (act_c != 0) begin
            act_s = act_c;
            rdy_end = rdy;
            act_c = 0;
        end
        lead_c = stb.cs_n ? 0 : lead_c + 1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wreq !== 1'b0);
        rdat = rdq;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic acc(input logic w, input logic [18:0] a);
        logic seen;
        seen = 1'b0;
        bus(1'b1, erw_pkg::ACCESS_OFS, {w, 12'h000, a});
        for (int n = 0; n < 1500 && !(seen && stb.cs_n === 1'b1); n++) begin
            @(posedge clk_i);
            seen |= (stb.cs_n === 1'b0);
        end
    endtask
    initial begin
        #300us;
        err_total++;
        close_out();
    end
    initial begin
        int k[8];
        int el, ea, ext, lo;
        logic [18:0] a;
        void'($urandom(29041));
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, erw_pkg::TIMING_OFS, 32'h0);
        chk(rdat, erw_pkg::TIMING_RST);
        bus(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0);
        for (int c = 0; c < 7; c++) begin
            k = cfg[c];
            el = k[0] + k[6];
            ea = k[1] + k[6];
            ext = k[7] + 1 - el;
            a = 19'($urandom);
            wait_n <= 4'(k[7]);
            pdat <= 16'($urandom);
            tv = 32'(k[0] | k[1] << 4 | k[2] << 8 | (k[0] + 1) << 12 | (k[1] + 1) << 16 | k[2] << 20
                | k[3] << 24 | k[4] << 25 | k[5] << 26);
            bus(1'b1, erw_pkg::TIMING_OFS, tv);
            bus(1'b0, erw_pkg::TIMING_OFS, 32'h0);
            chk(rdat, tv);
            bus(1'b1, erw_pkg::DATA_OFS, $urandom);
            acc(k[6][0], a);
            chk(xa, 32'(a));
            chk(lead_s, el * 8);
            lo = (k[3] && k[4]) ? ea - 2 : ea;
            if (k[3] && ext > lo) lo = ext;
            // Ready off, or synchronous ready up before the first sample: no stretch at all
            if (!k[3] || (!k[4] && ext < ea)) chk(act_s, ea * 8);
            else chk(act_s >= lo * 8 && act_s <= lo * 8 + 40, 1);
            if (k[3]) chk(rdy_end, 1'b1);
            if (!k[6]) bus(1'b0, erw_pkg::DATA_OFS, 32'h0);
            if (!k[6]) chk(rdat[15:0], pdat);
        end
        close_out();
    end
endmodule
`default_nettype wire
